/* File: rtl/rcwps_defines.svh */
// Constants for the reset-cause, watchdog and power-save block
//==============================================================
// Summary of operation
// - Power-on: PC zero, only power-on flag set
// - Pin reset: PC zero, set external flag
// - Software reset: PC zero, set software flag
// - Reset in sleep/idle also sets that flag
// - Watchdog overflow awake: full reset, timeout flag
// - Watchdog overflow asleep: resume PC+2, both flags
// - Interrupt wake from sleep: sleep flag, vector
// - Trap conflict, illegal operation set own flags
// - Flags software read/write, unrelated flags kept
// - Watchdog counts on low-power RC ticks
// - Config enable one forces watchdog on
// - Otherwise soft enable bit five controls it
// - Power-save instruction picks sleep or idle
// - Sleep stops clocks, fail-safe monitor; oscillator unless lowPowerCrystalInSleep
// - Sleep exits on interrupt, reset, watchdog
// - Wake restarts pre-sleep clock if switching enabled, else config clock
// - Wake holds clock for start-up delays
// - Clock dead after delay: trap or suspend
// - Idle stops CPU clock only, immediate wake
// - Idle wake sets idle flag, watchdog too
`ifndef RCWPS_DEFINES_SVH
`define RCWPS_DEFINES_SVH
//==============================================================
// Register map
`define RCW_OFS_CTL 8'h00
`define RCW_OFS_STAT 8'h04
`define RCW_F_TRAP 15
`define RCW_F_IOP 14
`define RCW_F_EXT 7
`define RCW_F_SOFT 6
`define RCW_F_WDT_EN 5
`define RCW_F_TIMEOUT 4
`define RCW_F_SLEEP 3
`define RCW_F_IDLE 2
`define RCW_F_POR 0
`define RCW_CTL_RST 16'h0001
`define RCW_CTL_WMASK 16'hC0FD
//==============================================================
// Vectors, widths and timing
`define RCW_RST_VEC 24'h000000
`define RCW_TRAP_VEC 24'h000004
`define RCW_PC_STEP 24'h000002
`define RCW_WDT_MAX 16'hFFFF
`define RCW_CLK_MHZ 200
`define RCW_PWR_DLY_NS 10000
`define RCW_PWR_DLY_CYC ((`RCW_PWR_DLY_NS * `RCW_CLK_MHZ + 999) / 1000)
`endif

/* File: rtl/rcwps_pkg.sv */
// Types for the reset-cause, watchdog and power-save block
package rcwps_pkg;
    //==========================================================
    // Power state and the kind of resume after a wake delay
    typedef enum logic [2:0] {
        RCW_RUN, RCW_SLEEP, RCW_IDLE, RCW_WAKE_DLY, RCW_WAKE_OSC, RCW_SUSPEND
    } rcwps_state_e;
    typedef enum logic [1:0] {RCW_K_SEQ, RCW_K_IRQ, RCW_K_RESET} rcwps_kind_e;
    //==========================================================
    // Whole state of the block
    typedef struct packed {
        rcwps_state_e state;
        rcwps_kind_e kind;
        logic porPend;
        logic fromSleep;
        logic [15:0] ctl;
        logic [15:0] wdtCnt;
        logic [11:0] dlyCnt;
        logic [23:0] pcRet;
        logic [23:0] pcOut;
        logic pcLoad;
        logic cpuRst;
        logic fastRcSwitch;
        logic [2:0] wakeOsc;
        logic [31:0] rdData;
    } rcwps_regs_s;
endpackage : rcwps_pkg

/* File: rtl/rcwps_top.sv */
// Reset-cause recorder, watchdog and sleep/idle sequencer
//
// Our own choices: strobed register access and the register addresses.
`include "rcwps_defines.svh"
module rcwps_top
    import rcwps_pkg::*;
(
    // Clock and reset (reset doubles as power-on)
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRData,
    // CPU events
    input wire logic externalResetPin,
    input wire logic softResetInstr,
    input wire logic trapConflict,
    input wire logic illegalOperation,
    input wire logic clockFailTrap,
    input wire logic clearWatchdogInstr,
    input wire logic powerSaveInstr,
    input wire logic powerSaveSleep,
    input wire logic [23:0] pcCurrent,
    input wire logic irqWake,
    input wire logic [23:0] irqVector,
    // Watchdog time base and configuration
    input wire logic lowPowerRcTick,
    input wire logic watchdogConfigEnable,
    // Oscillator status and configuration
    input wire logic clockSwitchEnable,
    input wire logic [2:0] currentOscillatorSelect,
    input wire logic [2:0] configOscSelect,
    input wire logic failSafeEnable,
    input wire logic oscIsCrystal,
    input wire logic usesPll,
    input wire logic lowPowerCrystalInSleep,
    input wire logic oscStartupDone,
    input wire logic pllLock,
    input wire logic oscRunning,
    // CPU control
    output logic pcLoad,
    output logic [23:0] pcLoadValue,
    output logic cpuReset,
    // Clock control
    output logic cpuClockEnable,
    output logic periphClockEnable,
    output logic oscEnable,
    output logic failSafeMonitorEnable,
    output logic lowPowerRcEnable,
    output logic systemClockHold,
    output logic switchToFastRc,
    output logic [2:0] wakeOscSelect
);
    //==========================================================
    // State
    rcwps_regs_s s_q;
    rcwps_regs_s s_d;
    logic wdtOn;
    logic wdtOvf;
    logic asleep;
    logic idling;
    logic running;

    // Apply a reset cause: clear, set, then mark the state it hit
    function automatic logic [15:0] causeFlags(
        input logic [15:0] f, input logic [15:0] clr, input logic [15:0] set,
        input logic inSleep, input logic inIdle);
        logic [15:0] r;
        r = (f & ~clr) | set;
        if (inSleep) r[`RCW_F_SLEEP] = 1'b1;
        if (inIdle) r[`RCW_F_IDLE] = 1'b1;
        return r;
    endfunction

    // One-hot mask of a flag bit
    function automatic logic [15:0] bitOf(input int unsigned pos);
        return 16'h0001 << pos;
    endfunction

    //==========================================================
    // Decodes of the current state
    assign asleep = (s_q.state == RCW_SLEEP);
    assign idling = (s_q.state == RCW_IDLE);
    assign running = (s_q.state == RCW_RUN);
    // Config bit wins; soft bit only matters when it is clear
    assign wdtOn = watchdogConfigEnable | s_q.ctl[`RCW_F_WDT_EN];
    assign wdtOvf = wdtOn && lowPowerRcTick && (s_q.wdtCnt == `RCW_WDT_MAX);

    //==========================================================
    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.pcLoad = 1'b0;
        s_d.cpuRst = 1'b0;
        s_d.fastRcSwitch = 1'b0;
        // Read data stand for exactly one cycle after the strobe
        s_d.rdData = 32'h00000000;
        if (regRd) begin
            unique case (regAddr)
                `RCW_OFS_CTL: s_d.rdData = {16'h0000, s_q.ctl};
                `RCW_OFS_STAT: s_d.rdData = {s_q.wdtCnt, 13'h0000,
                                             systemClockHold, asleep, idling};
                default: s_d.rdData = 32'h00000000;
            endcase
        end
        // Software write first so a hardware cause below wins
        if (regWr && regAddr == `RCW_OFS_CTL) begin
            s_d.ctl = regWData[15:0] & `RCW_CTL_WMASK;
        end
        // Free-running count on RC ticks, so a dead main clock can't hide it
        if (!wdtOn || clearWatchdogInstr) begin
            s_d.wdtCnt = 16'h0000;
        end else if (lowPowerRcTick) begin
            s_d.wdtCnt = s_q.wdtCnt + 16'h0001;
        end
        // Clock to restart after sleep follows the switch setting
        s_d.wakeOsc = clockSwitchEnable ? currentOscillatorSelect
                                        : configOscSelect;

        // Resets, highest priority first; unrelated flags stay untouched
        if (externalResetPin) begin
            s_d.ctl = causeFlags(s_d.ctl,
                bitOf(`RCW_F_TIMEOUT) | bitOf(`RCW_F_SLEEP) | bitOf(`RCW_F_IDLE)
                | (running ? bitOf(`RCW_F_SOFT) : 16'h0000),
                bitOf(`RCW_F_EXT), asleep, idling);
        end else if (trapConflict) begin
            s_d.ctl = causeFlags(s_d.ctl, 16'h0000, bitOf(`RCW_F_TRAP),
                asleep, idling);
        end else if (illegalOperation) begin
            s_d.ctl = causeFlags(s_d.ctl, 16'h0000, bitOf(`RCW_F_IOP),
                asleep, idling);
        end else if (wdtOvf && running) begin
            s_d.ctl = causeFlags(s_d.ctl,
                bitOf(`RCW_F_EXT) | bitOf(`RCW_F_SOFT) | bitOf(`RCW_F_SLEEP)
                | bitOf(`RCW_F_IDLE), bitOf(`RCW_F_TIMEOUT), 1'b0, 1'b0);
        end else if (softResetInstr && running) begin
            s_d.ctl = causeFlags(s_d.ctl,
                bitOf(`RCW_F_EXT) | bitOf(`RCW_F_TIMEOUT) | bitOf(`RCW_F_SLEEP)
                | bitOf(`RCW_F_IDLE), bitOf(`RCW_F_SOFT), 1'b0, 1'b0);
        end

        if (externalResetPin || trapConflict || illegalOperation
            || (wdtOvf && running) || (softResetInstr && running)) begin
            s_d.wdtCnt = 16'h0000;
            s_d.cpuRst = 1'b1;
            s_d.kind = RCW_K_RESET;
            if (asleep) begin
                // The oscillator was off: the wake delays still apply
                s_d.state = RCW_WAKE_DLY;
                s_d.fromSleep = 1'b1;
                s_d.dlyCnt = 12'(`RCW_PWR_DLY_CYC - 1);
            end else if (running || idling) begin
                s_d.state = RCW_RUN;
                s_d.pcLoad = 1'b1;
                s_d.pcOut = `RCW_RST_VEC;
            end
        end else begin
            unique case (s_q.state)
                RCW_RUN: begin
                    if (clockFailTrap) begin
                        // Vector only; cause flags are left alone
                        s_d.pcLoad = 1'b1;
                        s_d.pcOut = `RCW_TRAP_VEC;
                    end else if (powerSaveInstr) begin
                        s_d.pcRet = 24'(pcCurrent + `RCW_PC_STEP);
                        s_d.state = powerSaveSleep ? RCW_SLEEP : RCW_IDLE;
                    end
                end
                RCW_SLEEP: begin
                    if (irqWake || wdtOvf) begin
                        s_d.ctl[`RCW_F_SLEEP] = 1'b1;
                        if (wdtOvf && !irqWake) begin
                            s_d.ctl[`RCW_F_TIMEOUT] = 1'b1;
                        end
                        s_d.kind = irqWake ? RCW_K_IRQ : RCW_K_SEQ;
                        s_d.fromSleep = 1'b1;
                        s_d.state = RCW_WAKE_DLY;
                        s_d.dlyCnt = 12'(`RCW_PWR_DLY_CYC - 1);
                    end
                end
                RCW_IDLE: begin
                    // No start-up delay: the clock source never stopped
                    if (irqWake) begin
                        s_d.ctl[`RCW_F_IDLE] = 1'b1;
                        s_d.state = RCW_RUN;
                        s_d.pcLoad = 1'b1;
                        s_d.pcOut = irqVector;
                    end else if (wdtOvf) begin
                        s_d.ctl[`RCW_F_IDLE] = 1'b1;
                        s_d.ctl[`RCW_F_TIMEOUT] = 1'b1;
                        s_d.state = RCW_RUN;
                        s_d.pcLoad = 1'b1;
                        s_d.pcOut = s_q.pcRet;
                    end
                end
                RCW_WAKE_DLY: begin
                    // Power-on delay always applies
                    if (s_q.dlyCnt != 12'h000) begin
                        s_d.dlyCnt = s_q.dlyCnt - 12'h001;
                    end else if (usesPll || (oscIsCrystal
                               && !(lowPowerCrystalInSleep && s_q.fromSleep))) begin
                        s_d.state = RCW_WAKE_OSC;
                    end else begin
                        s_d.state = RCW_SUSPEND;
                    end
                end
                RCW_WAKE_OSC: begin
                    // Hold until start-up timer expires and PLL locks
                    if ((!oscIsCrystal || oscStartupDone) && (!usesPll || pllLock)) begin
                        if (!oscRunning && failSafeEnable) begin
                            // Dead clock: trap and fall back to fast RC
                            s_d.state = RCW_RUN;
                            s_d.pcLoad = 1'b1;
                            s_d.pcOut = `RCW_TRAP_VEC;
                            s_d.fastRcSwitch = 1'b1;
                            s_d.porPend = 1'b0;
                            s_d.fromSleep = 1'b0;
                        end else begin
                            s_d.state = RCW_SUSPEND;
                        end
                    end
                end
                RCW_SUSPEND: begin
                    // Execution stays frozen until the clock is stable
                    if (oscRunning || (!oscIsCrystal && !usesPll)) begin
                        s_d.state = RCW_RUN;
                        s_d.pcLoad = 1'b1;
                        s_d.porPend = 1'b0;
                        s_d.fromSleep = 1'b0;
                        unique case (s_q.kind)
                            RCW_K_IRQ: s_d.pcOut = irqVector;
                            RCW_K_SEQ: s_d.pcOut = s_q.pcRet;
                            default: s_d.pcOut = `RCW_RST_VEC;
                        endcase
                    end
                end
                default: s_d.state = RCW_RUN;
            endcase
        end
    end

    //==========================================================
    // State register; power-on leaves only the power-on flag set
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q.state <= RCW_WAKE_DLY;
            s_q.kind <= RCW_K_RESET;
            s_q.porPend <= 1'b1;
            s_q.fromSleep <= 1'b0;
            s_q.ctl <= `RCW_CTL_RST;
            s_q.wdtCnt <= 16'h0000;
            s_q.dlyCnt <= 12'(`RCW_PWR_DLY_CYC - 1);
            s_q.pcRet <= `RCW_RST_VEC;
            s_q.pcOut <= `RCW_RST_VEC;
            s_q.pcLoad <= 1'b0;
            s_q.cpuRst <= 1'b0;
            s_q.fastRcSwitch <= 1'b0;
            s_q.wakeOsc <= 3'h0;
            s_q.rdData <= 32'h00000000;
        end else begin
            s_q <= s_d;
        end
    end

    //==========================================================
    // Outputs
    assign regRData = s_q.rdData;
    assign pcLoad = s_q.pcLoad;
    assign pcLoadValue = s_q.pcOut;
    assign cpuReset = s_q.cpuRst;
    assign switchToFastRc = s_q.fastRcSwitch;
    assign wakeOscSelect = s_q.wakeOsc;
    // Clock gating decodes straight off the state flops
    assign cpuClockEnable = running;
    assign periphClockEnable = running || idling;
    assign oscEnable = !asleep || lowPowerCrystalInSleep;
    assign failSafeMonitorEnable = failSafeEnable && !asleep;
    assign lowPowerRcEnable = wdtOn || (failSafeEnable && !asleep);
    assign systemClockHold = (s_q.state == RCW_WAKE_DLY)
                          || (s_q.state == RCW_WAKE_OSC)
                          || (s_q.state == RCW_SUSPEND);
endmodule // rcwps_top

/* File: tb/rcwps_chk.sv */
// Port checker for the reset-cause, watchdog and power-save block
module rcwps_chk
    import rcwps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Register port
    input wire logic regRd,
    input wire logic [31:0] regRData,
    // Events
    input wire logic externalResetPin,
    input wire logic softResetInstr,
    input wire logic trapConflict,
    input wire logic illegalOperation,
    input wire logic clockFailTrap,
    input wire logic powerSaveInstr,
    input wire logic powerSaveSleep,
    input wire logic irqWake,
    input wire logic [23:0] irqVector,
    input wire logic lowPowerRcTick,
    // CPU and clock control
    input wire logic pcLoad,
    input wire logic [23:0] pcLoadValue,
    input wire logic cpuReset,
    input wire logic cpuClockEnable,
    input wire logic periphClockEnable,
    input wire logic systemClockHold
);
    timeunit 1ns;
    timeprecision 1ps;
    //==========================================================
    // State seen from the clock enables; quiet hides higher-priority causes
    logic quiet;
    logic running;
    logic idling;
    assign quiet = !externalResetPin && !trapConflict && !illegalOperation && !lowPowerRcTick;
    assign running = cpuClockEnable && !systemClockHold;
    assign idling = !cpuClockEnable && periphClockEnable && !systemClockHold;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    //==========================================================
    // Assertions
    ext_pin_reset_a: assert property (
        externalResetPin && running |=> cpuReset && pcLoad && pcLoadValue == 24'h000000)
        else $error("pin reset did not vector to zero");
    soft_reset_a: assert property (
        softResetInstr && running && quiet |=> cpuReset && pcLoad && pcLoadValue == 24'h000000)
        else $error("software reset did not vector to zero");
    trap_reset_a: assert property (
        (trapConflict || illegalOperation) && running |=> cpuReset && pcLoad && pcLoadValue == 24'h0)
        else $error("trap or illegal reset did not vector to zero");
    clock_fail_a: assert property (
        clockFailTrap && running && quiet && !softResetInstr && !powerSaveInstr
        |=> pcLoad && !cpuReset && pcLoadValue == 24'h000004)
        else $error("clock fail trap vector wrong");
    sleep_entry_a: assert property (
        powerSaveInstr && powerSaveSleep && running && quiet && !softResetInstr && !clockFailTrap
        |=> !cpuClockEnable && !periphClockEnable)
        else $error("sleep left a clock running");
    idle_entry_a: assert property (
        powerSaveInstr && !powerSaveSleep && running && quiet && !softResetInstr && !clockFailTrap
        |=> !cpuClockEnable && periphClockEnable)
        else $error("idle clock gating wrong");
    idle_wake_a: assert property (
        irqWake && idling && quiet && !softResetInstr
        |=> pcLoad && cpuClockEnable && pcLoadValue == $past(irqVector))
        else $error("idle interrupt wake wrong");
    read_idle_a: assert property (
        !regRd |=> regRData == 32'h0)
        else $error("read data outside read slot");
    pc_hold_a: assert property (
        $changed(pcLoadValue) |-> pcLoad)
        else $error("load value moved without a load");
    // Main scenarios
    soft_c: cover property (softResetInstr && running);
    idle_wake_c: cover property (irqWake && idling);
    trap_vec_c: cover property (pcLoad && pcLoadValue == 24'h000004);
endmodule // rcwps_chk

bind rcwps_top rcwps_chk chk_u (
    .clk(clk), .sys_rst(sys_rst), .regRd(regRd), .regRData(regRData),
    .externalResetPin(externalResetPin), .softResetInstr(softResetInstr),
    .trapConflict(trapConflict), .illegalOperation(illegalOperation),
    .clockFailTrap(clockFailTrap), .powerSaveInstr(powerSaveInstr),
    .powerSaveSleep(powerSaveSleep), .irqWake(irqWake), .irqVector(irqVector),
    .lowPowerRcTick(lowPowerRcTick), .pcLoad(pcLoad), .pcLoadValue(pcLoadValue),
    .cpuReset(cpuReset), .cpuClockEnable(cpuClockEnable),
    .periphClockEnable(periphClockEnable), .systemClockHold(systemClockHold)
);

/* File: tb/rcwps_osc_model.sv */
// Oscillator status and low-power RC tick source facing the block
module rcwps_osc_model #(
    parameter int START_CYC = 40
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Control from the block and the bench
    input wire logic oscEnable,
    input wire logic lowPowerRcEnable,
    input wire logic tickOn,
    // Oscillator status and watchdog time base
    output logic oscStartupDone,
    output logic pllLock,
    output logic oscRunning,
    output logic lowPowerRcTick
);
    timeunit 1ns;
    timeprecision 1ps;
    int startCnt_q;
    // A stopped oscillator restarts from zero, so slow start-up is seen every wake from sleep
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst || !oscEnable) begin
            startCnt_q <= 0;
        end else if (startCnt_q < START_CYC) begin
            startCnt_q <= startCnt_q + 1;
        end
    end
    assign oscRunning = (startCnt_q == START_CYC);
    assign oscStartupDone = oscRunning;
    assign pllLock = oscRunning;
    // RC ticks only while the block keeps the RC clock on
    assign lowPowerRcTick = tickOn && lowPowerRcEnable;
endmodule // rcwps_osc_model

/* File: tb/tb_top.sv */
// Self-checking bench for the reset-cause, watchdog and power-save block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rcwps_pkg::*;
    logic clk = 0, sys_rst = 1, regWr = 0, regRd = 0, wdCfg = 0, crystal = 0, fsEn = 0;
    logic tickOn = 0, psSleep = 0, csEn = 1, pcLoad, cpuClockEnable, periphClockEnable;
    logic oscEnable, lowPowerRcEnable, oscStartupDone, pllLock, oscRunning, tick;
    logic [7:0] regAddr = 8'h00, evt = 8'h00;
    logic [31:0] regWData = 32'h0, regRData;
    logic [23:0] evtVal = 24'h0, pcLoadValue;
    logic [2:0] wakeOscSelect;
    logic [15:0] pre [5] = '{16'h8000, 16'h8000, 16'h4000, 16'h8000, 16'h8040};
    logic [15:0] post [5] = '{16'h8080, 16'h8040, 16'hC000, 16'hC000, 16'h8040};
    int err_total = 0;
    int comparisons = 0;
    int n;
    always #2.5 clk = ~clk;
    //==========================================================
    // Design and oscillator model
    rcwps_top dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWData(regWData),
        .regWr(regWr), .regRd(regRd), .regRData(regRData), .externalResetPin(evt[0]),
        .softResetInstr(evt[1]), .trapConflict(evt[2]), .illegalOperation(evt[3]),
        .clockFailTrap(evt[4]), .clearWatchdogInstr(evt[5]), .powerSaveInstr(evt[7]),
        .powerSaveSleep(psSleep), .pcCurrent(evtVal), .irqWake(evt[6]), .irqVector(evtVal),
        .lowPowerRcTick(tick), .watchdogConfigEnable(wdCfg), .clockSwitchEnable(csEn),
        .currentOscillatorSelect(3'h5), .configOscSelect(3'h2), .failSafeEnable(fsEn),
        .oscIsCrystal(crystal), .usesPll(1'b0), .lowPowerCrystalInSleep(1'b0),
        .oscStartupDone(oscStartupDone), .pllLock(pllLock), .oscRunning(oscRunning),
        .pcLoad(pcLoad), .pcLoadValue(pcLoadValue), .cpuReset(),
        .cpuClockEnable(cpuClockEnable), .periphClockEnable(periphClockEnable),
        .oscEnable(oscEnable), .failSafeMonitorEnable(), .lowPowerRcEnable(lowPowerRcEnable),
        .systemClockHold(), .switchToFastRc(), .wakeOscSelect(wakeOscSelect));
    rcwps_osc_model osc_u (.clk(clk), .sys_rst(sys_rst), .oscEnable(oscEnable),
        .lowPowerRcEnable(lowPowerRcEnable), .tickOn(tickOn), .oscStartupDone(oscStartupDone),
        .pllLock(pllLock), .oscRunning(oscRunning), .lowPowerRcTick(tick));
    //==========================================================
    // Drivers and compare
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        regAddr <= a;
        regWData <= v;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 cmp(regRData, e);
    endtask
    // One-cycle event pulse; the value feeds both the PC and the vector input
    task automatic kick(input int k, input logic s, input logic [23:0] v);
        @(posedge clk);
        evt <= 8'h01 << k;
        psSleep <= s;
        evtVal <= v;
        @(posedge clk);
        evt <= 8'h00;
        #1;
    endtask
    task automatic ticks(input int m);
        @(posedge clk);
        tickOn <= 1'b1;
        repeat (m) @(posedge clk);
        tickOn <= 1'b0;
    endtask
    // Bounded wait for a PC load; n returns the cycles waited
    task automatic wait_pc(input int lim);
        n = 0;
        while (pcLoad !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= lim) cmp(32'h1, 32'h0);
    endtask
    task automatic finish_test();
        $display("Mismatches %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    //==========================================================
    // Tests
    initial begin
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        wait_pc(2100);
        cmp({8'h0, pcLoadValue}, 32'h0);
        chk_reg(8'h00, 32'h1);
        cmp({29'h0, wakeOscSelect}, 32'h5);
        chk_reg(8'h08, 32'h0);
        wr(8'h00, 32'hFFFF_FFFF);
        chk_reg(8'h00, 32'hC0FD);
        for (int k = 0; k < 5; k++) begin
            wr(8'h00, {16'h0, pre[k]});
            kick(k, 1'b0, 24'h0);
            cmp({31'h0, pcLoad}, 32'h1);
            cmp({8'h0, pcLoadValue}, (k == 4) ? 32'h4 : 32'h0);
            chk_reg(8'h00, {16'h0, post[k]});
        end
        wr(8'h00, 32'h0);
        kick(7, 1'b0, 24'h000100);
        cmp({30'h0, cpuClockEnable, periphClockEnable}, 32'h1);
        kick(6, 1'b0, 24'h000200);
        cmp({8'h0, pcLoadValue}, 32'h200);
        chk_reg(8'h00, 32'h4);
        wr(8'h00, 32'h0);
        kick(7, 1'b0, 24'h000100);
        kick(0, 1'b0, 24'h0);
        chk_reg(8'h00, 32'h84);
        wr(8'h00, 32'h0);
        kick(7, 1'b1, 24'h000300);
        cmp({29'h0, cpuClockEnable, periphClockEnable, oscEnable}, 32'h0);
        kick(6, 1'b0, 24'h000500);
        wait_pc(2100);
        cmp({31'h0, n >= 2000}, 32'h1);
        cmp({8'h0, pcLoadValue}, 32'h500);
        chk_reg(8'h00, 32'h8);
        // Watchdog enables, clear and counting through the status word
        wr(8'h00, 32'h0);
        ticks(4);
        chk_reg(8'h04, 32'h0);
        wr(8'h00, 32'h20);
        ticks(4);
        chk_reg(8'h04, 32'h0004_0000);
        kick(5, 1'b0, 24'h0);
        chk_reg(8'h04, 32'h0);
        wr(8'h00, 32'h0);
        @(posedge clk);
        wdCfg <= 1'b1;
        ticks(5);
        chk_reg(8'h04, 32'h0005_0000);
        // Watchdog wake from sleep on a crystal clock
        @(posedge clk);
        crystal <= 1'b1;
        fsEn <= 1'b1;
        kick(5, 1'b0, 24'h0);
        @(posedge clk);
        tickOn <= 1'b1;
        kick(7, 1'b1, 24'h000400);
        wait_pc(70000);
        cmp({8'h0, pcLoadValue}, 32'h402);
        @(posedge clk);
        tickOn <= 1'b0;
        csEn <= 1'b0;
        chk_reg(8'h00, 32'h18);
        cmp({29'h0, wakeOscSelect}, 32'h2);
        finish_test();
    end
    // Hang guard, well past the longest expected run
    initial begin
        #500us;
        err_total++;
        finish_test();
    end
endmodule // tb_top
